// ### design/pmbus_access_control.sv
// PMBus decode: write lock, addressing, channel config.
// Assumes async pins; bus far below CLK_I/8.
//
// Contract
// - Indirect read answers in one packet; page kept.
// - Non-paged indirect target ignores page byte.
// - Indirect read: block write, block read process call.
// - Nested indirect command: NACK packet, raise fault.
// - Protect pin overrides lock; lock never shows pin.
// - Lock zero accepts every write except lock values with bits 4:0 set.
// - Protect pin: only page, operation, peaks, unlock, clear.
// - Own address 7 bits; 0x80 disables it.
// - Global addresses 0x5A, 0x5B always answer.
// - Low select pin sets LSB, high pin MSB.
// - Open pin keeps stored address bits.
// - Rail address reaches current page's channel.
// - Rail read contention raises fault.
// - Rail address 0x80 disables it.
// - Bit 4: run pin not pulled low when off.
// - Bit 2: output off while phase clock low.
// - Bit 1: no alert from external GPIO low.
// - Bit 0 clear: wait for decay before restart.
// - Short cycle, bit 3 set: off now, restart after 120ms.
// - Short cycle, bit 3 clear: normal off, then 120ms.
// - Channel config resets 0x1D, shared 0x21.
// - Lock at 0x10; own address at 0xE6, default 0x4F.
`default_nettype none
`include "pmbus_access_map.svh"
module pmbus_access_control
#(
    parameter int NCH          = 2,
    parameter int WAIT_CYCLES  = (`CLK_FREQ_HZ / 1000) * `RESTART_WAIT_MS
)
(
    // Clock and reset
    input  wire logic                          CLK_I,
    input  wire logic                          NRST_I,
    // SMBus
    input  wire logic                          SCL_I,
    input  wire logic                          SDA_I,
    output logic                               SDA_OE_N_O,
    output logic                               ALERT_OE_N_O,
    // Pins
    input  wire logic                          WP_I,
    input  wire pmbus_access_pkg::strap_t      ADDR_SELECT_LOW_PIN_I,
    input  wire pmbus_access_pkg::strap_t      ADDR_SELECT_HIGH_PIN_I,
    input  wire logic                          SHARED_PHASE_CLOCK_I,
    // Per channel
    input  wire logic [1:0]                    RUN_I,
    input  wire logic [1:0]                    GPIO_LOW_I,
    input  wire logic [1:0]                    OFF_DONE_I,
    input  wire logic [1:0]                    DECAYED_I,
    output logic      [1:0]                    RUN_OE_N_O,
    output logic      [1:0]                    CH_ENABLE_O,
    output logic      [1:0]                    SHORT_CYCLE_O,
    // Status
    output logic                               COMMUNICATION_FAULT_O
);
    import pmbus_access_pkg::*;

    initial if (NCH != 2) $error("NCH must be 2");

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    logic [7:0] s1_r, s2_r;
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            s1_r <= `SYNC_IDLE;
            s2_r <= `SYNC_IDLE;
        end
        else
        begin
            s1_r <= {SCL_I, SDA_I, WP_I, SHARED_PHASE_CLOCK_I, RUN_I, GPIO_LOW_I};
            s2_r <= s1_r;
        end
    end
    logic scl_s, sda_s, wp_s, shclk_s;
    logic [1:0] run_s, gpio_s;
    assign {scl_s, sda_s, wp_s, shclk_s, run_s, gpio_s} = s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine
    logic start, stop, bytev, first, ack, rd_req, rd_mode, mism;
    logic [7:0] rx, rd_data;
    smbus_slave_rx u_rx
    (
        .clk_i      (CLK_I),
        .nrst_i     (NRST_I),
        .scl_i      (scl_s),
        .sda_i      (sda_s),
        .sda_oe_n_o (SDA_OE_N_O),
        .start_o    (start),
        .stop_o     (stop),
        .byte_o     (bytev),
        .data_o     (rx),
        .first_o    (first),
        .ack_i      (ack),
        .rd_req_o   (rd_req),
        .rd_data_i  (rd_data),
        .rd_mode_o  (rd_mode),
        .mismatch_o (mism)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic is_paged(input logic [7:0] c);
        return c == `CMD_CHAN_CONFIG || c == `CMD_RAIL_ADDR || c == `CMD_OPERATION
            || c == `CMD_ON_OFF_CONFIG || c == `CMD_VOUT_COMMAND;
    endfunction

    // Write permission by lock level and protect pin
    function automatic logic wr_ok(input logic [7:0] c, input logic [7:0] lvl, input logic wp);
        logic a, b, d;
        a = c == `CMD_WRITE_LOCK || c == `CMD_PAGE || c == `CMD_NVM_UNLOCK || c == `CMD_STORE_ALL;
        b = a || c == `CMD_CLEAR_PEAKS || c == `CMD_OPERATION || c == `CMD_CLEAR_FAULTS;
        d = b || c == `CMD_ON_OFF_CONFIG || c == `CMD_VOUT_COMMAND;
        if (wp)
            return c == `CMD_PAGE || c == `CMD_OPERATION || c == `CMD_CLEAR_PEAKS
                || c == `CMD_NVM_UNLOCK || c == `CMD_CLEAR_FAULTS;
        if (lvl[7])
            return a;
        if (lvl[6])
            return b;
        if (lvl[5])
            return d;
        return 1'b1;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Address resolution from straps
    logic [6:0] own_addr;
    logic [7:0] own_addr_r, lock_r, page_r, shared_r;
    logic [7:0] chan_r [2], rail_r [2];
    always_comb
    begin
        own_addr = own_addr_r[6:0];
        if (ADDR_SELECT_HIGH_PIN_I != PIN_OPEN)
            own_addr[6] = ADDR_SELECT_HIGH_PIN_I == PIN_HIGH;
        if (ADDR_SELECT_LOW_PIN_I != PIN_OPEN)
            own_addr[0] = ADDR_SELECT_LOW_PIN_I == PIN_HIGH;
    end
    logic sel_ch;
    assign sel_ch = page_r == 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    typedef enum logic [2:0] {P_ADDR, P_CMD, P_DATA, P_PPCNT, P_PPPAGE, P_PPCMD, P_IDLE} ph_t;
    ph_t        ph_r, ph_nxt;
    logic [7:0] cmd_r, cmd_nxt, ppg_r, ppg_nxt, tcmd_r, tcmd_nxt;
    logic       rail_r_acc, rail_acc_nxt, pp_r, pp_nxt, cml_r, cml_nxt;
    logic       wr_en;
    logic [7:0] wdata, wcmd;
    logic       wch;
    logic [1:0] rcnt_r, rcnt_nxt;

    function automatic logic [7:0] rd_reg(input logic [7:0] c, input logic ch);
        unique case (c)
            `CMD_PAGE:          return page_r;
            `CMD_WRITE_LOCK:    return lock_r;
            `CMD_OWN_ADDR:      return own_addr_r;
            `CMD_RAIL_ADDR:     return rail_r[ch];
            `CMD_CHAN_CONFIG:   return chan_r[ch];
            `CMD_SHARED_CONFIG: return shared_r;
            default:            return 8'hFF;
        endcase
    endfunction

    always_comb
    begin
        ph_nxt = ph_r;
        cmd_nxt = cmd_r;
        ppg_nxt = ppg_r;
        tcmd_nxt = tcmd_r;
        rail_acc_nxt = rail_r_acc;
        pp_nxt = pp_r;
        cml_nxt = (cml_r && !(cmd_r == `CMD_CLEAR_FAULTS && ph_r == P_DATA && stop)) || (mism && rail_r_acc);
        rcnt_nxt = rcnt_r;
        ack = 1'b0;
        wr_en = 1'b0;
        wdata = rx;
        wcmd = cmd_r;
        wch = sel_ch;
        rd_data = 8'hFF;
        if (start)
            ph_nxt = P_ADDR;
        if (bytev)
        begin
            unique case (ph_r)
                P_ADDR:
                begin
                    ack = rx[7:1] == `GLOBAL_ADDR_A || rx[7:1] == `GLOBAL_ADDR_B
                        || (own_addr_r != `ADDR_DISABLE && rx[7:1] == own_addr)
                        || (rail_r[sel_ch] != `ADDR_DISABLE && rx[7:1] == rail_r[sel_ch][6:0]);
                    rail_acc_nxt = rail_r[sel_ch] != `ADDR_DISABLE && rx[7:1] == rail_r[sel_ch][6:0];
                    if (!rx[0])
                    begin
                        ph_nxt = ack ? P_CMD : P_IDLE;
                        pp_nxt = 1'b0;
                    end
                    rcnt_nxt = 2'd0;
                end
                P_CMD:
                begin
                    ack = 1'b1;
                    cmd_nxt = rx;
                    ph_nxt = rx == `CMD_PAGE_PLUS_RD ? P_PPCNT : P_DATA;
                end
                P_PPCNT:
                begin
                    ack = 1'b1;
                    ph_nxt = P_PPPAGE;
                end
                P_PPPAGE:
                begin
                    ack = 1'b1;
                    ppg_nxt = rx;
                    ph_nxt = P_PPCMD;
                end
                P_PPCMD:
                begin
                    if (rx == `CMD_PAGE_PLUS_RD || rx == `CMD_PAGE_PLUS_WR)
                    begin
                        ack = 1'b0;
                        cml_nxt = 1'b1;
                        ph_nxt = P_IDLE;
                    end
                    else
                    begin
                        ack = 1'b1;
                        tcmd_nxt = rx;
                        pp_nxt = 1'b1;
                        ph_nxt = P_IDLE;
                    end
                end
                P_DATA:
                begin
                    ack = wr_ok(cmd_r, lock_r, wp_s) && !(cmd_r == `CMD_WRITE_LOCK && (rx & `LOCK_RSVD_MASK) != 8'h00);
                    wr_en = ack;
                    if (!ack)
                        cml_nxt = 1'b1;
                    ph_nxt = P_IDLE;
                end
                P_IDLE:
                    ack = 1'b0;
            endcase
        end
        if (rd_req)
        begin
            rcnt_nxt = rcnt_r + 2'd1;
            if (pp_r)
                rd_data = rcnt_r == 2'd0 ? 8'h01
                    : rd_reg(tcmd_r, is_paged(tcmd_r) ? ppg_r == 8'h01 : sel_ch);
            else
                rd_data = rd_reg(cmd_r, sel_ch);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            ph_r <= P_IDLE;
            cmd_r <= 8'h00;
            ppg_r <= 8'h00;
            tcmd_r <= 8'h00;
            rail_r_acc <= 1'b0;
            pp_r <= 1'b0;
            cml_r <= 1'b0;
            rcnt_r <= 2'd0;
            page_r <= `RST_PAGE;
            lock_r <= `RST_WRITE_LOCK;
            own_addr_r <= `RST_OWN_ADDR;
            shared_r <= `RST_SHARED_CONFIG;
            chan_r <= '{`RST_CHAN_CONFIG, `RST_CHAN_CONFIG};
            rail_r <= '{`RST_RAIL_ADDR, `RST_RAIL_ADDR};
        end
        else
        begin
            ph_r <= ph_nxt;
            cmd_r <= cmd_nxt;
            ppg_r <= ppg_nxt;
            tcmd_r <= tcmd_nxt;
            rail_r_acc <= rail_acc_nxt;
            pp_r <= pp_nxt;
            cml_r <= cml_nxt;
            rcnt_r <= rcnt_nxt;
            if (wr_en)
            begin
                unique case (wcmd)
                    `CMD_PAGE:          page_r <= wdata;
                    `CMD_WRITE_LOCK:    lock_r <= wdata;
                    `CMD_OWN_ADDR:      own_addr_r <= wdata;
                    `CMD_SHARED_CONFIG: shared_r <= wdata;
                    `CMD_CHAN_CONFIG:
                    begin
                        if (page_r == `PAGE_ALL)
                            chan_r <= '{wdata, wdata};
                        else
                            chan_r[wch] <= wdata;
                    end
                    `CMD_RAIL_ADDR:
                    begin
                        if (page_r == `PAGE_ALL)
                            rail_r <= '{wdata, wdata};
                        else
                            rail_r[wch] <= wdata;
                    end
                    default:;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channels
    logic [1:0] en, alert;
    for (genvar g = 0; g < 2; g++)
    begin : g_ch
        restart_timer #(.WAIT_CYCLES(WAIT_CYCLES)) u_tmr
        (
            .clk_i      (CLK_I),
            .nrst_i     (NRST_I),
            .on_cmd_i   (run_s[g]),
            .off_done_i (OFF_DONE_I[g]),
            .decayed_i  (DECAYED_I[g]),
            .short_en_i (chan_r[g][`CC_SHORT_CYCLE]),
            .no_decay_i (chan_r[g][`CC_NO_DECAY_WAIT]),
            .enable_o   (en[g]),
            .short_o    (SHORT_CYCLE_O[g])
        );
        assign CH_ENABLE_O[g] = en[g] && !(chan_r[g][`CC_SHARE_CLK_EN] && !shclk_s);
        assign RUN_OE_N_O[g] = en[g] || chan_r[g][`CC_NO_RUN_LOW];
        assign alert[g] = gpio_s[g] && !chan_r[g][`CC_NO_GPIO_ALERT];
    end

    assign ALERT_OE_N_O = !(cml_r || |alert);
    assign COMMUNICATION_FAULT_O = cml_r;
endmodule
`default_nettype wire

// ### design/pmbus_access_map.svh
// Command codes, reset values and timing of the access logic.
// Definitions only.
`ifndef PMBUS_ACCESS_MAP_SVH
`define PMBUS_ACCESS_MAP_SVH

// Command codes
`define CMD_OPERATION      8'h01
`define CMD_ON_OFF_CONFIG  8'h02
`define CMD_CLEAR_FAULTS   8'h03
`define CMD_PAGE           8'h00
`define CMD_PAGE_PLUS_WR   8'h05
`define CMD_PAGE_PLUS_RD   8'h06
`define CMD_WRITE_LOCK     8'h10
`define CMD_STORE_ALL      8'h15
`define CMD_VOUT_COMMAND   8'h21
`define CMD_CHAN_CONFIG    8'hD0
`define CMD_SHARED_CONFIG  8'hD1
`define CMD_CLEAR_PEAKS    8'hE3
`define CMD_NVM_UNLOCK     8'hBD
`define CMD_OWN_ADDR       8'hE6
`define CMD_RAIL_ADDR      8'hFA

// Reset values
`define RST_CHAN_CONFIG    8'h1D
`define RST_SHARED_CONFIG  8'h21
`define RST_WRITE_LOCK     8'h00
`define RST_OWN_ADDR       8'h4F
`define RST_RAIL_ADDR      8'h80
`define RST_PAGE           8'h00
// Idle pins: bus high, no protect, phase clock high, run and GPIO inactive
`define SYNC_IDLE          8'hD0

// Lock and address constants
`define LOCK_RSVD_MASK     8'h1F
`define ADDR_DISABLE       8'h80
`define GLOBAL_ADDR_A      7'h5A
`define GLOBAL_ADDR_B      7'h5B
`define PAGE_ALL           8'hFF

// Channel config bits
`define CC_NO_RUN_LOW      4
`define CC_SHORT_CYCLE     3
`define CC_SHARE_CLK_EN    2
`define CC_NO_GPIO_ALERT   1
`define CC_NO_DECAY_WAIT   0

// Timing
`define RESTART_WAIT_MS    120
`define CLK_FREQ_HZ        100000000

`endif

// ### design/pmbus_access_pkg.sv
// Types shared by the PMBus access logic.
// Assumes the map header is compiled alongside.
`default_nettype none
package pmbus_access_pkg;
    typedef enum logic [1:0]
    {
        PIN_LOW,
        PIN_HIGH,
        PIN_OPEN
    } strap_t;
endpackage
`default_nettype wire

// ### design/smbus_slave_rx.sv
// SMBus slave byte engine with open-drain ACK and read data.
// Assumes the parent synchronises scl and sda.
`default_nettype none
module smbus_slave_rx
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Synchronised bus lines
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_n_o,
    // Byte stream to the parent
    output logic            start_o,
    output logic            stop_o,
    output logic            byte_o,
    output logic [7:0]      data_o,
    output logic            first_o,
    input  wire logic       ack_i,
    output logic            rd_req_o,
    input  wire logic [7:0] rd_data_i,
    output logic            rd_mode_o,
    output logic            mismatch_o
);
    logic       scl_d_r, sda_d_r;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic       act_r, act_nxt, frst_r, frst_nxt, rd_r, rd_nxt;
    logic       ackph_r, ackph_nxt, oe_r, oe_nxt, mack_r, mack_nxt;
    logic       rise, fall, st, sp;

    assign rise = scl_i & ~scl_d_r;
    assign fall = ~scl_i & scl_d_r;
    assign st = scl_i & scl_d_r & sda_d_r & ~sda_i;
    assign sp = scl_i & scl_d_r & ~sda_d_r & sda_i;

    always_comb
    begin
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        act_nxt = act_r;
        frst_nxt = frst_r;
        rd_nxt = rd_r;
        ackph_nxt = ackph_r;
        oe_nxt = oe_r;
        mack_nxt = mack_r;
        start_o = st;
        stop_o = sp;
        byte_o = 1'b0;
        rd_req_o = 1'b0;
        mismatch_o = 1'b0;
        if (st)
        begin
            act_nxt = 1'b1;
            frst_nxt = 1'b1;
            rd_nxt = 1'b0;
            bit_nxt = 4'd0;
            ackph_nxt = 1'b0;
            oe_nxt = 1'b1;
        end
        else if (sp)
        begin
            act_nxt = 1'b0;
            oe_nxt = 1'b1;
        end
        else if (act_r && rise && !ackph_r)
        begin
            sh_nxt = {sh_r[6:0], sda_i};
            // Released bit seen low: contention
            if (rd_r && oe_r && !sda_i)
                mismatch_o = 1'b1;
            bit_nxt = bit_r + 4'd1;
        end
        else if (act_r && rise && ackph_r)
            mack_nxt = sda_i;
        else if (act_r && fall)
        begin
            if (bit_r == 4'd8 && !ackph_r)
            begin
                ackph_nxt = 1'b1;
                if (!rd_r)
                begin
                    byte_o = 1'b1;
                    oe_nxt = ~ack_i;
                end
                else
                    oe_nxt = 1'b1;
            end
            else if (ackph_r)
            begin
                ackph_nxt = 1'b0;
                bit_nxt = 4'd0;
                frst_nxt = 1'b0;
                // The ack request is gone by now; our own ACK drive remembers it
                if (frst_r && oe_r)
                    act_nxt = 1'b0;
                if (frst_r && sh_r[0] && !oe_r)
                    rd_nxt = 1'b1;
                if ((frst_r && sh_r[0] && !oe_r) || (rd_r && !mack_r))
                begin
                    rd_req_o = 1'b1;
                    sh_nxt = rd_data_i;
                    oe_nxt = rd_data_i[7];
                end
                else
                begin
                    if (rd_r)
                        act_nxt = 1'b0;
                    oe_nxt = 1'b1;
                end
            end
            else if (rd_r)
                oe_nxt = sh_r[7];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            sh_r <= 8'h00;
            bit_r <= 4'd0;
            act_r <= 1'b0;
            frst_r <= 1'b0;
            rd_r <= 1'b0;
            ackph_r <= 1'b0;
            oe_r <= 1'b1;
            mack_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_i;
            sda_d_r <= sda_i;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            act_r <= act_nxt;
            frst_r <= frst_nxt;
            rd_r <= rd_nxt;
            ackph_r <= ackph_nxt;
            oe_r <= oe_nxt;
            mack_r <= mack_nxt;
        end
    end

    assign data_o = sh_r;
    assign first_o = frst_r;
    assign rd_mode_o = rd_r;
    assign sda_oe_n_o = oe_r;
endmodule
`default_nettype wire

// ### design/restart_timer.sv
// Per-channel off and restart sequencer.
// Assumes WAIT_CYCLES spans the restart wait.
`default_nettype none
`include "pmbus_access_map.svh"
module restart_timer
#(
    parameter int WAIT_CYCLES = 12000000
)
(
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic on_cmd_i,
    input  wire logic off_done_i,
    input  wire logic decayed_i,
    input  wire logic short_en_i,
    input  wire logic no_decay_i,
    output logic      enable_o,
    output logic      short_o
);
    typedef enum logic [1:0] {ST_OFF, ST_ON, ST_FALL, ST_WAIT} seq_t;
    seq_t        st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic        pend_r, pend_nxt, ev;

    initial if (WAIT_CYCLES < 1) $error("WAIT_CYCLES below one");

    always_comb
    begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        pend_nxt = pend_r;
        ev = 1'b0;
        unique case (st_r)
            ST_OFF:
                if (on_cmd_i && (decayed_i || no_decay_i))
                    st_nxt = pend_r ? ST_WAIT : ST_ON;
            ST_ON:
                if (!on_cmd_i)
                    st_nxt = ST_FALL;
            ST_FALL:
                if (on_cmd_i && !off_done_i)
                begin
                    ev = 1'b1;
                    pend_nxt = 1'b1;
                    if (short_en_i)
                    begin
                        st_nxt = ST_WAIT;
                        cnt_nxt = 32'd0;
                    end
                end
                else if (off_done_i)
                begin
                    st_nxt = ST_OFF;
                    cnt_nxt = 32'd0;
                end
            ST_WAIT:
                if (cnt_r >= 32'(WAIT_CYCLES - 1))
                begin
                    pend_nxt = 1'b0;
                    st_nxt = ST_OFF;
                end
                else
                    cnt_nxt = cnt_r + 32'd1;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st_r <= ST_OFF;
            cnt_r <= 32'd0;
            pend_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign enable_o = (st_r == ST_ON) || (st_r == ST_FALL && !(on_cmd_i && short_en_i));
    assign short_o = ev;
endmodule
`default_nettype wire

// ### tb/pmbus_host.sv
// SMBus host model, 125 ns bit time.
// Assumes SDA pulled up.
`default_nettype none
module pmbus_host
(
    // Alignment and bus
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic nak = 0;
    initial {scl_o, sda_o} = 2'b11;
    task q; #31.25; endtask
    // Start off the clock edge
    task st; @(posedge clk_i) #0.5; sda_o = 1; q; scl_o = 1; q; sda_o = 0; q; scl_o = 0; q; endtask
    task sp; sda_o = 0; q; scl_o = 1; q; sda_o = 1; q; endtask
    // m: 0 ack, 1 nack, 2 device acks
    task xb(input logic [7:0] d, input logic [1:0] m, output logic [7:0] r);
        logic k;
        for (int i = 8; i >= 0; i--)
        begin
            sda_o = (i > 0) ? d[i-1] : (m != 0); q; scl_o = 1; q;
            k = sda_i; if (i > 0) r[i-1] = k; q; scl_o = 0; q;
        end
        if (m == 2) nak |= k;
    endtask
endmodule
`default_nettype wire

// ### tb/pmbus_access_control_props.sv
// Pin checker for the access control block.
// Assumes channel 1 config stays at reset.
`default_nettype none
module pmbus_access_control_props
#(parameter int WAIT_CYCLES = 100)
(
    input wire logic       CLK_I, NRST_I, SCL_I, SHARED_PHASE_CLOCK_I,
    input wire logic       SDA_OE_N_O, ALERT_OE_N_O, COMMUNICATION_FAULT_O,
    input wire logic [1:0] GPIO_LOW_I, CH_ENABLE_O, SHORT_CYCLE_O, RUN_OE_N_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    // Cycles since the last short cycle; starts saturated
    int cnt_r;
    always_ff @(posedge CLK_I or negedge NRST_I)
        if (!NRST_I) cnt_r <= WAIT_CYCLES;
        else if (SHORT_CYCLE_O[1]) cnt_r <= 0;
        else if (cnt_r < WAIT_CYCLES) cnt_r <= cnt_r + 1;
    sequence clk_held_s; !SHARED_PHASE_CLOCK_I [*4]; endsequence
    sequence gpio_held_s; GPIO_LOW_I[1] [*4]; endsequence
    clk_gate_a: assert property (clk_held_s |-> !CH_ENABLE_O[1]) else $error("enable with clock low");
    run_float_a: assert property (!CH_ENABLE_O[1] |-> RUN_OE_N_O[1]) else $error("run pulled low");
    gpio_alert_a: assert property (gpio_held_s |-> !ALERT_OE_N_O) else $error("no gpio alert");
    short_pulse_a: assert property (SHORT_CYCLE_O[1] |=> !SHORT_CYCLE_O[1]) else $error("long pulse");
    short_off_a: assert property (SHORT_CYCLE_O[1] |-> ##[0:2] !CH_ENABLE_O[1]) else $error("no off");
    restart_wait_a: assert property ($rose(CH_ENABLE_O[1]) |-> cnt_r >= WAIT_CYCLES - 4) else $error("early");
    fault_alert_a: assert property (COMMUNICATION_FAULT_O |-> !ALERT_OE_N_O) else $error("fault silent");
    sda_frame_a: assert property ($changed(SDA_OE_N_O) |-> !SCL_I) else $error("sda moved, scl high");
endmodule
bind pmbus_access_control pmbus_access_control_props #(.WAIT_CYCLES(WAIT_CYCLES)) u_props (.*);
`default_nettype wire

// ### tb/pmbus_access_control_tb.sv
// Bench for the access control block.
// Assumes pmbus_host is the only master.
`default_nettype none
module pmbus_access_control_tb;
    import pmbus_access_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [6:0] A = 7'h4F;
    localparam int WAIT = 100;
    logic clk = 0, nrst = 0, wp = 0, spc = 1, scl, hsda, sda_oe_n, alert_n, fault;
    logic [1:0] run = 0, gpio = 0, offd = 2'b11, dec = 0, run_n, en, shc;
    logic [7:0] r;
    int n_mismatch = 0, num_checks = 0;
    wire logic sda = hsda & sda_oe_n;
    pmbus_host h (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));
    pmbus_access_control #(.WAIT_CYCLES(WAIT)) dut (.CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda),
        .SDA_OE_N_O(sda_oe_n), .ALERT_OE_N_O(alert_n), .WP_I(wp), .ADDR_SELECT_LOW_PIN_I(PIN_OPEN),
        .ADDR_SELECT_HIGH_PIN_I(PIN_OPEN), .SHARED_PHASE_CLOCK_I(spc), .RUN_I(run), .GPIO_LOW_I(gpio),
        .OFF_DONE_I(offd), .DECAYED_I(dec), .RUN_OE_N_O(run_n), .CH_ENABLE_O(en),
        .SHORT_CYCLE_O(shc), .COMMUNICATION_FAULT_O(fault));
    task test_done;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input string s, input logic [7:0] e, g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    // nd: send byte without data; e: nack expected
    task wr(input logic [6:0] a, input logic [7:0] c, d, input logic nd, e);
        h.nak = 0; h.st; h.xb({a, 1'b0}, 2, r); h.xb(c, 2, r);
        if (!nd) h.xb(d, 2, r);
        h.sp; chk("nack", {7'h0, e}, {7'h0, h.nak});
    endtask
    task rd(input logic [6:0] a, input logic [7:0] c, e);
        h.st; h.xb({a, 1'b0}, 2, r); h.xb(c, 2, r); h.st; h.xb({a, 1'b1}, 2, r);
        h.xb(8'hFF, 1, r); h.sp; chk("read", e, r);
    endtask
    task pph(input logic [7:0] p, c);
        h.nak = 0; h.st; h.xb({A, 1'b0}, 2, r); h.xb(8'h06, 2, r); h.xb(8'h02, 2, r); h.xb(p, 2, r); h.xb(c, 2, r);
    endtask
    task ppr(input logic [7:0] p, c, e);
        pph(p, c); h.st; h.xb({A, 1'b1}, 2, r); h.xb(8'hFF, 0, r); chk("count", 8'h01, r);
        h.xb(8'hFF, 1, r); h.sp; chk("paged", e, r);
    endtask
    task wen(input int n, input logic v);
        for (int k = 0; k < n && en[1] !== v; k++) @(posedge clk);
        chk("enable", {7'h0, v}, {7'h0, en[1]});
        if (en[1] !== v) test_done;
    endtask
    task t_reg;
        rd(A, 8'hD0, 8'h1D);
        rd(A, 8'hD1, 8'h21);
        rd(A, 8'hE6, 8'h4F);
    endtask
    task t_lock;
        wr(A, 8'h10, 8'h80, 0, 0);
        wr(A, 8'hD1, 8'h00, 0, 1);
        rd(A, 8'hD1, 8'h21);
        wr(A, 8'h10, 8'h40, 0, 0);
        wr(A, 8'h03, 8'h00, 1, 0);
        wr(A, 8'h02, 8'h1E, 0, 1);
        wr(A, 8'h10, 8'h20, 0, 0);
        wr(A, 8'h02, 8'h1E, 0, 0);
        chk("fault", 8'h01, {7'h0, fault});
        wr(A, 8'h10, 8'h00, 0, 0);
        wr(A, 8'hD1, 8'h21, 0, 0);
    endtask
    task t_wp;
        @(posedge clk) wp <= 1;
        wr(A, 8'h10, 8'h80, 0, 1);
        rd(A, 8'h10, 8'h00);
        wr(A, 8'h00, 8'h00, 0, 0);
        wr(A, 8'h03, 8'h00, 1, 0);
        chk("fault", 8'h00, {7'h0, fault});
        @(posedge clk) wp <= 0;
    endtask
    task t_addr;
        wr(A, 8'hE6, 8'h80, 0, 0);
        rd(A, 8'hD1, 8'hFF);
        rd(7'h5B, 8'hD1, 8'h21);
        wr(7'h5A, 8'hE6, 8'h4F, 0, 0);
        wr(A, 8'hFA, 8'h30, 0, 0);
        wr(7'h30, 8'h01, 8'h80, 0, 0);
        wr(A, 8'hFA, 8'h80, 0, 0);
        wr(7'h30, 8'h01, 8'h80, 0, 1);
    endtask
    task t_chan;
        wr(A, 8'h00, 8'hFF, 0, 0);
        wr(A, 8'h01, 8'h80, 0, 0);
        wr(A, 8'h00, 8'h00, 0, 0);
        wr(A, 8'hD0, 8'h1F, 0, 0);
        @(posedge clk) run <= 2'b10;
        wen(3 * WAIT, 1);
        @(posedge clk) {run, offd} <= 4'b0000;
        repeat (5) @(posedge clk);
        run <= 2'b10;
        wen(20, 0);
        @(posedge clk) offd <= 2'b11;
        wen(3 * WAIT, 1);
        @(posedge clk) spc <= 0;
        wen(20, 0);
        @(posedge clk) {spc, gpio} <= 3'b101;
        repeat (5) @(posedge clk);
        chk("alert", 8'h01, {7'h0, alert_n});
        gpio <= 2'b10;
        repeat (5) @(posedge clk);
        gpio <= 0;
    endtask
    task t_ppr;
        ppr(8'h01, 8'hD0, 8'h1D);
        rd(A, 8'h00, 8'h00);
        ppr(8'h01, 8'hD1, 8'h21);
        pph(8'h00, 8'h06);
        h.sp;
        chk("nested", 8'h01, {7'h0, h.nak});
        chk("fault", 8'h01, {7'h0, fault});
    endtask
    initial forever #5 clk = ~clk;
    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        repeat (3) @(posedge clk);
        t_reg; t_lock; t_wp; t_addr; t_chan; t_ppr;
        test_done;
    end
endmodule
`default_nettype wire
